// *** inc/sil_defines.svh ***
`ifndef SIL_DEFINES_SVH
`define SIL_DEFINES_SVH
// ****************************************
// timing
// ****************************************
`define SIL_CLK_NS 4
`define SIL_TICK_MS 100
`define SIL_TICK_CYC (`SIL_TICK_MS * 1000000 / `SIL_CLK_NS)
`define SIL_HALF_TICKS(ms) ((ms) / 2 / `SIL_TICK_MS)
`define SIL_P_1HZ_MS 1000
`define SIL_P_1HZ25_MS 800
`define SIL_P_2HZ5_MS 400
`define SIL_P_5HZ_MS 200
`define SIL_WARMUP_MS 60000
`define SIL_WARMUP_TICKS (`SIL_WARMUP_MS / `SIL_TICK_MS)
`define SIL_PULSE_MS 200
`define SIL_PULSE_TICKS (`SIL_PULSE_MS / `SIL_TICK_MS)
// ****************************************
// thresholds and patterns
// ****************************************
`define SIL_TEMP_COLD 8'he7
`define SIL_TEMP_WARM 8'hec
`define SIL_BUS_RED_BLINKS 4
// ****************************************
// register map
// ****************************************
`define SIL_OFS_CTRL 8'h00
`define SIL_OFS_STATUS 8'h04
`define SIL_CTRL_EN 0
`define SIL_CTRL_BRIGHT 1
`define SIL_CTRL_COL 2
`define SIL_CTRL_SRC 5
`define SIL_CTRL_DEMO 7
`define SIL_CTRL_CARDREQ 8
`define SIL_CTRL_RST 32'h0000_0013
`define SIL_ST_READY 0
`define SIL_ST_WARM 1
`define SIL_ST_COLD 2
`define SIL_ST_CARDMISS 3
`define SIL_ST_BLINKIDX 4
`endif

// *** inc/sil_pkg.sv ***
`default_nettype none
package sil_pkg;
   typedef enum logic [2:0] {
      SIL_OFF = 3'h0,
      SIL_GREEN = 3'h1,
      SIL_RED = 3'h2,
      SIL_ORANGE = 3'h3,
      SIL_BLUE = 3'h4
   } sil_colour_e;
   typedef enum logic [1:0] {
      SIL_SRC_SEQ = 2'h0,
      SIL_SRC_CMD = 2'h1,
      SIL_SRC_EVAL = 2'h2
   } sil_src_e;
endpackage : sil_pkg
`default_nettype wire

// *** inc/sil_tick_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface sil_tick_if;
   logic tick;
   logic [3:0] phase;
   modport src (output tick, output phase);
   modport snk (input tick, input phase);
endinterface : sil_tick_if
`default_nettype wire

// *** src/sil_timebase.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sil_defines.svh"
module sil_timebase #(
   parameter int unsigned TICK_CYC = `SIL_TICK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   sil_tick_if.src tb
);
   import sil_pkg::*;
   localparam int CW = $clog2(TICK_CYC + 1);
   // phase 0: 1 Hz, 1: 1.25 Hz, 2: 2.5 Hz, 3: 5 Hz
   localparam logic [3:0] HALF [4] = '{
      4'(`SIL_HALF_TICKS(`SIL_P_1HZ_MS)),
      4'(`SIL_HALF_TICKS(`SIL_P_1HZ25_MS)),
      4'(`SIL_HALF_TICKS(`SIL_P_2HZ5_MS)),
      4'(`SIL_HALF_TICKS(`SIL_P_5HZ_MS))};
   logic [CW-1:0] cyc;
   logic tick_q;

   // one shared prescaler keeps every rate in step and small
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc <= '0;
         tick_q <= 1'b0;
      end else if (cyc == CW'(TICK_CYC - 1)) begin
         cyc <= '0;
         tick_q <= 1'b1;
      end else begin
         cyc <= cyc + 1'b1;
         tick_q <= 1'b0;
      end
   end
   assign tb.tick = tick_q;

   // equal on and off halves for every rate
   for (genvar g = 0; g < 4; g++) begin : g_rate
      logic [3:0] cnt;
      logic ph;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt <= 4'h0;
            ph <= 1'b0;
         end else if (tick_q) begin
            if (cnt == HALF[g] - 4'h1) begin
               cnt <= 4'h0;
               ph <= ~ph;
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
      assign tb.phase[g] = ph;
   end
endmodule : sil_timebase
`default_nettype wire

// *** src/sil_top.sv ***
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sil_defines.svh"
module sil_top #(
   parameter int unsigned TICK_CYC = `SIL_TICK_CYC,
   parameter int unsigned WARMUP_TICKS = `SIL_WARMUP_TICKS,
   parameter int TAG_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic signed [7:0] temp_c,
   input wire logic hw_fault,
   input wire logic fieldbus_down,
   input wire logic field_on,
   input wire logic rf_fault,
   input wire logic eth_activity,
   input wire logic card_present,
   input wire logic card_readable,
   input wire logic card_write_start,
   input wire logic read_interval,
   input wire logic good_read,
   input wire logic no_read,
   input wire logic fb_cmd,
   input wire logic fb_eval_hit,
   input wire logic [TAG_W-1:0] tag_count,
   output sil_pkg::sil_colour_e ready_lamp,
   output sil_pkg::sil_colour_e radio_lamp,
   output logic link_lamp,
   output sil_pkg::sil_colour_e card_lamp,
   output sil_pkg::sil_colour_e fb_lamp [4],
   output logic fb_full [4],
   output logic ready_for_use,
   output logic demo_read_req
);
   import sil_pkg::*;

   localparam int WW = $clog2(WARMUP_TICKS + 1);
   localparam logic [1:0] PULSE_T = 2'(`SIL_PULSE_TICKS);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ****************************************
   // timebase
   // ****************************************
   sil_tick_if tb ();
   sil_timebase #(
      .TICK_CYC(TICK_CYC)
   ) u_tb (
      .hclk(hclk),
      .hresetn(hresetn),
      .tb(tb.src)
   );

   // ****************************************
   // register bus
   // ****************************************
   logic [31:0] ctrl;
   logic [31:0] status;
   logic wr_pend;
   logic [1:0] wr_idx;

   // 1: ctrl, 2: status, 0: unmapped
   function automatic logic [1:0] reg_idx(input logic [31:0] a);
      if (a[31:8] != 24'h0 || a[1:0] != 2'h0) begin
         return 2'h0;
      end
      unique case (a[7:0])
         `SIL_OFS_CTRL: return 2'h1;
         `SIL_OFS_STATUS: return 2'h2;
         default: return 2'h0;
      endcase
   endfunction : reg_idx

   logic take;
   assign take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 2'h0;
      end else if (hready) begin
         wr_pend <= take && hwrite;
         wr_idx <= reg_idx(haddr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `SIL_CTRL_RST;
      end else if (wr_pend && wr_idx == 2'h1) begin
         ctrl <= hwdata;
      end
   end

   // read data is taken during the address phase; a write still in its
   // data phase to ctrl is forwarded so back-to-back reads see it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (take && !hwrite) begin
         unique case (reg_idx(haddr))
            2'h1: hrdata <= (wr_pend && wr_idx == 2'h1) ? hwdata : ctrl;
            2'h2: hrdata <= status;
            default: hrdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic cfg_en;
   logic cfg_full;
   sil_colour_e cfg_col;
   sil_src_e cfg_src;
   logic cfg_demo;
   logic card_required_setting;
   assign cfg_en = ctrl[`SIL_CTRL_EN];
   assign cfg_full = ctrl[`SIL_CTRL_BRIGHT];
   assign cfg_col = sil_colour_e'(ctrl[`SIL_CTRL_COL +: 3]);
   assign cfg_src = sil_src_e'(ctrl[`SIL_CTRL_SRC +: 2]);
   assign cfg_demo = ctrl[`SIL_CTRL_DEMO];
   assign card_required_setting = ctrl[`SIL_CTRL_CARDREQ];

   // ****************************************
   // readiness and warm-up
   // ****************************************
   logic too_cold;
   logic in_warmup;
   logic [WW-1:0] warm_cnt;
   logic warm_done;
   logic next_ready;
   assign too_cold = temp_c < $signed(`SIL_TEMP_COLD);
   assign in_warmup = !too_cold && temp_c < $signed(`SIL_TEMP_WARM)
      && !warm_done;

   // the count restarts if the device falls back below the cold limit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warm_cnt <= '0;
         warm_done <= 1'b0;
      end else if (too_cold) begin
         warm_cnt <= '0;
         warm_done <= 1'b0;
      end else if (in_warmup && tb.tick) begin
         if (warm_cnt == WW'(WARMUP_TICKS - 1)) begin
            warm_done <= 1'b1;
         end
         warm_cnt <= warm_cnt + 1'b1;
      end
   end

   assign next_ready = !hw_fault && !too_cold && !in_warmup;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_for_use <= 1'b0;
      end else begin
         ready_for_use <= next_ready;
      end
   end

   // ****************************************
   // fieldbus connection pattern
   // ****************************************
   logic [2:0] blink_idx;
   logic ph1_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph1_q <= 1'b0;
         blink_idx <= 3'h0;
      end else begin
         ph1_q <= tb.phase[0];
         if (!fieldbus_down) begin
            blink_idx <= 3'h0;
         end else if (ph1_q && !tb.phase[0]) begin
            blink_idx <= (blink_idx == 3'(`SIL_BUS_RED_BLINKS))
               ? 3'h0 : blink_idx + 3'h1;
         end
      end
   end

   // ****************************************
   // panel lamps
   // ****************************************
   sil_colour_e next_ready_lamp;
   always_comb begin
      next_ready_lamp = SIL_GREEN;
      if (hw_fault) begin
         next_ready_lamp = SIL_RED;
      end else if (too_cold) begin
         next_ready_lamp = tb.phase[0] ? SIL_ORANGE : SIL_OFF;
      end else if (in_warmup) begin
         next_ready_lamp = tb.phase[0] ? SIL_GREEN : SIL_OFF;
      end else if (fieldbus_down) begin
         if (!tb.phase[0]) begin
            next_ready_lamp = SIL_OFF;
         end else if (blink_idx < 3'(`SIL_BUS_RED_BLINKS)) begin
            next_ready_lamp = SIL_RED;
         end else begin
            next_ready_lamp = SIL_GREEN;
         end
      end
   end

   // a card-write request without a card stays flagged until one is
   // inserted or the setting is cleared; set and clear cannot meet since set needs no card
   logic card_missing;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         card_missing <= 1'b0;
      end else if (card_required_setting && card_write_start
                   && !card_present) begin
         card_missing <= 1'b1;
      end else if (card_present || !card_required_setting) begin
         card_missing <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_lamp <= SIL_OFF;
         radio_lamp <= SIL_OFF;
         link_lamp <= 1'b0;
         card_lamp <= SIL_OFF;
      end else begin
         ready_lamp <= next_ready_lamp;
         radio_lamp <= rf_fault ? SIL_RED
            : field_on ? SIL_GREEN : SIL_OFF;
         link_lamp <= eth_activity;
         // readiness only; card traffic is not shown
         card_lamp <= card_missing ? SIL_ORANGE
            : !card_present ? SIL_OFF
            : card_readable ? SIL_GREEN : SIL_RED;
      end
   end

   // ****************************************
   // process feedback
   // ****************************************
   logic [1:0] pulse_cnt;
   sil_colour_e pulse_col;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt <= 2'h0;
         pulse_col <= SIL_OFF;
      end else if (good_read || no_read) begin
         pulse_cnt <= PULSE_T;
         pulse_col <= good_read ? SIL_GREEN : SIL_RED;
      end else if (pulse_cnt != 2'h0 && tb.tick) begin
         pulse_cnt <= pulse_cnt - 2'h1;
      end
   end

   sil_colour_e next_fb_col;
   logic next_fb_full;
   logic demo_phase;
   always_comb begin
      next_fb_col = SIL_OFF;
      next_fb_full = cfg_full;
      demo_phase = 1'b0;
      if (tag_count > TAG_W'(2)) begin
         demo_phase = tb.phase[3];
      end else if (tag_count == TAG_W'(2)) begin
         demo_phase = tb.phase[2];
      end else begin
         demo_phase = tb.phase[1];
      end
      if (cfg_demo) begin
         // fixed pattern, configuration is not consulted
         next_fb_full = 1'b1;
         if (!field_on) begin
            next_fb_col = SIL_OFF;
         end else if (tag_count == '0) begin
            next_fb_col = SIL_BLUE;
            next_fb_full = 1'b0;
         end else begin
            next_fb_col = demo_phase ? SIL_BLUE : SIL_OFF;
         end
      end else if (cfg_en) begin
         unique case (cfg_src)
            SIL_SRC_SEQ: begin
               if (pulse_cnt != 2'h0) begin
                  next_fb_col = pulse_col;
               end else if (read_interval) begin
                  next_fb_col = SIL_BLUE;
               end
            end
            SIL_SRC_CMD: next_fb_col = fb_cmd ? cfg_col : SIL_OFF;
            SIL_SRC_EVAL: next_fb_col = fb_eval_hit ? cfg_col : SIL_OFF;
            default: next_fb_col = SIL_OFF;
         endcase
      end
   end

   // one source value fans out so the four lamps can never differ
   for (genvar g = 0; g < 4; g++) begin : g_fb
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            fb_lamp[g] <= SIL_OFF;
            fb_full[g] <= 1'b0;
         end else begin
            fb_lamp[g] <= next_fb_col;
            fb_full[g] <= next_fb_full;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         demo_read_req <= 1'b0;
      end else begin
         demo_read_req <= cfg_demo;
      end
   end

   assign status = {25'h0, blink_idx, card_missing, too_cold,
      in_warmup, ready_for_use};

   // ****************************************
   // checks
   // ****************************************
   sequence s_cold;
      !hw_fault && too_cold;
   endsequence
   sequence s_good;
      !cfg_demo && cfg_en && cfg_src == SIL_SRC_SEQ && good_read;
   endsequence
   sequence s_demo_idle;
      cfg_demo && field_on && tag_count == '0;
   endsequence

   a_fault_red: assert property (hw_fault |=> ready_lamp == SIL_RED
      && !ready_for_use) else $error("fault not shown red");
   a_cold_blink: assert property (s_cold |=> !ready_for_use &&
      (ready_lamp == SIL_ORANGE || ready_lamp == SIL_OFF))
      else $error("cold state not orange");
   a_ready_green: assert property ($past(hresetn) && next_ready
      && !fieldbus_down |=> ready_lamp == SIL_GREEN && ready_for_use)
      else $error("ready not steady green");
   a_radio_lamp: assert property (!rf_fault && field_on |=>
      radio_lamp == SIL_GREEN) else $error("radio not green");
   a_radio_fault: assert property (rf_fault |=> radio_lamp == SIL_RED)
      else $error("radio fault not red");
   a_link_lamp: assert property (link_lamp == $past(eth_activity))
      else $error("link lamp lags");
   a_card_bad: assert property (card_present && !card_readable
      && !card_missing |=> card_lamp == SIL_RED)
      else $error("bad card not red");
   a_card_orange: assert property (card_required_setting
      && card_write_start && !card_present |=> ##1
      card_lamp == SIL_ORANGE) else $error("missing card");
   a_fb_same: assert property (fb_lamp[0] == fb_lamp[3]
      && fb_full[1] == fb_full[2] && fb_lamp[1] == fb_lamp[2]
      && fb_full[0] == fb_full[3]) else $error("lamps differ");
   a_fb_off: assert property (!cfg_demo && !cfg_en |=>
      fb_lamp[0] == SIL_OFF) else $error("disabled lamp lit");
   a_demo_half: assert property (s_demo_idle |=>
      fb_lamp[0] == SIL_BLUE && !fb_full[0])
      else $error("demo idle not half blue");
   a_good_green: assert property (s_good |=> ##1
      fb_lamp[0] == SIL_GREEN || !cfg_en || cfg_demo)
      else $error("good read not green");
endmodule : sil_top
`default_nettype wire

// *** dv/sil_lamp_viewer.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************
// operator view of the ready and feedback lamps
// ****************
module sil_lamp_viewer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire sil_pkg::sil_colour_e ready_lamp,
   input wire sil_pkg::sil_colour_e fb_lamp [4],
   input wire logic fb_full [4],
   output var int fb_half,
   output var int rdy_half,
   output var int split_cnt
);
   import sil_pkg::*;
   sil_colour_e rdy_prev;
   sil_colour_e fb_prev;
   int rdy_run;
   int fb_run;
   // an operator sees only the lamps, so runs are measured in whole cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         split_cnt <= 0;
      end else if (fb_lamp[1] !== fb_lamp[0] || fb_lamp[2] !== fb_lamp[0] ||
                   fb_lamp[3] !== fb_lamp[0] || fb_full[1] !== fb_full[0] ||
                   fb_full[2] !== fb_full[0] || fb_full[3] !== fb_full[0]) begin
         split_cnt <= split_cnt + 1;
      end
   end
   // length of the last steady run of each lamp, both halves alike
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdy_prev <= SIL_OFF;
         rdy_run <= 0;
         rdy_half <= 0;
      end else if (ready_lamp !== rdy_prev) begin
         rdy_prev <= ready_lamp;
         rdy_half <= rdy_run;
         rdy_run <= 1;
      end else begin
         rdy_run <= rdy_run + 1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fb_prev <= SIL_OFF;
         fb_run <= 0;
         fb_half <= 0;
      end else if (fb_lamp[0] !== fb_prev) begin
         fb_prev <= fb_lamp[0];
         fb_half <= fb_run;
         fb_run <= 1;
      end else begin
         fb_run <= fb_run + 1;
      end
   end
endmodule : sil_lamp_viewer
`default_nettype wire

// *** dv/sil_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sil_defines.svh"
module sil_tb_top;
   import sil_pkg::*;
   localparam int TICK = 4;
   localparam int WARM = 12;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic signed [7:0] temp_c;
   logic hw_fault, fieldbus_down, field_on, rf_fault, eth_activity;
   logic card_present, card_readable, read_interval, fb_cmd, fb_eval_hit;
   logic card_write_start, good_read, no_read;
   logic [7:0] tag_count;
   sil_colour_e ready_lamp, radio_lamp, card_lamp;
   sil_colour_e fb_lamp [4];
   logic fb_full [4];
   logic link_lamp, ready_for_use, demo_read_req;
   int fb_half, rdy_half, split_cnt, hp;
   int fail_count = 0;
   int checks_done = 0;
   assign hready = hreadyout;
   // ****************
   // design and lamp viewer
   // ****************
   sil_top #(.TICK_CYC(TICK), .WARMUP_TICKS(WARM)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .temp_c(temp_c), .hw_fault(hw_fault), .fieldbus_down(fieldbus_down),
      .field_on(field_on), .rf_fault(rf_fault), .eth_activity(eth_activity),
      .card_present(card_present), .card_readable(card_readable),
      .card_write_start(card_write_start), .read_interval(read_interval),
      .good_read(good_read), .no_read(no_read), .fb_cmd(fb_cmd),
      .fb_eval_hit(fb_eval_hit), .tag_count(tag_count),
      .ready_lamp(ready_lamp), .radio_lamp(radio_lamp), .link_lamp(link_lamp),
      .card_lamp(card_lamp), .fb_lamp(fb_lamp), .fb_full(fb_full),
      .ready_for_use(ready_for_use), .demo_read_req(demo_read_req));
   sil_lamp_viewer viewer (.hclk(hclk), .hresetn(hresetn),
      .ready_lamp(ready_lamp), .fb_lamp(fb_lamp), .fb_full(fb_full),
      .fb_half(fb_half), .rdy_half(rdy_half), .split_cnt(split_cnt));
   // ****************
   // tasks
   // ****************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // single word transfer; waits on hready, the watchdog bounds a hang
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", hresp, 1'b0);
   endtask : ahb
   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task see_rdy(input sil_colour_e c);
      int i;
      for (i = 0; i < 200 && ready_lamp !== c; i++) @(posedge hclk);
      chk("ready_lamp", ready_lamp, c);
   endtask : see_rdy
   task end_sim;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      end_sim();
   end
   // ****************
   // tests
   // ****************
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      temp_c = 8'h19;
      {hw_fault, fieldbus_down, field_on, rf_fault, eth_activity} = '0;
      {card_present, card_readable, read_interval, fb_cmd, fb_eval_hit} = '0;
      {card_write_start, good_read, no_read} = '0;
      tag_count = 8'h00;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `SIL_OFS_CTRL, 32'h0);
      chk("ctrl reset", rd, `SIL_CTRL_RST);
      ahb(1'b1, 32'h8, 32'hffff_ffff);
      ahb(1'b0, 32'h8, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("ready lamp", ready_lamp, SIL_GREEN);
      chk("ready flag", ready_for_use, 1'b1);
      hw_fault <= 1'b1;
      cyc(3);
      chk("fault lamp", ready_lamp, SIL_RED);
      chk("fault ready", ready_for_use, 1'b0);
      hw_fault <= 1'b0;
      temp_c <= 8'he2;
      cyc(60);
      chk("cold half", rdy_half, `SIL_HALF_TICKS(`SIL_P_1HZ_MS) * TICK);
      see_rdy(SIL_ORANGE);
      see_rdy(SIL_OFF);
      chk("cold ready", ready_for_use, 1'b0);
      temp_c <= 8'hea;
      ahb(1'b0, `SIL_OFS_STATUS, 32'h0);
      chk("warm status", rd[`SIL_ST_WARM], 1'b1);
      see_rdy(SIL_GREEN);
      chk("warm ready", ready_for_use, 1'b0);
      cyc(60);
      chk("warm done", ready_for_use, 1'b1);
      chk("steady lamp", ready_lamp, SIL_GREEN);
      fieldbus_down <= 1'b1;
      see_rdy(SIL_RED);
      see_rdy(SIL_GREEN);
      for (int i = 0; i < 5; i++) begin
         see_rdy(SIL_OFF);
         while (ready_lamp === SIL_OFF) @(posedge hclk);
         chk("bus blink", ready_lamp, i < 4 ? SIL_RED : SIL_GREEN);
      end
      fieldbus_down <= 1'b0;
      field_on <= 1'b1;
      eth_activity <= 1'b1;
      card_present <= 1'b1;
      card_readable <= 1'b1;
      cyc(3);
      chk("radio on", radio_lamp, SIL_GREEN);
      chk("link on", link_lamp, 1'b1);
      chk("card ok", card_lamp, SIL_GREEN);
      rf_fault <= 1'b1;
      eth_activity <= 1'b0;
      card_readable <= 1'b0;
      cyc(3);
      chk("radio fault", radio_lamp, SIL_RED);
      chk("link off", link_lamp, 1'b0);
      chk("card bad", card_lamp, SIL_RED);
      rf_fault <= 1'b0;
      card_present <= 1'b0;
      ahb(1'b1, `SIL_OFS_CTRL, 32'h113);
      card_write_start <= 1'b1;
      cyc(1);
      card_write_start <= 1'b0;
      cyc(3);
      chk("card missing", card_lamp, SIL_ORANGE);
      card_present <= 1'b1;
      card_readable <= 1'b1;
      read_interval <= 1'b1;
      cyc(3);
      chk("card back", card_lamp, SIL_GREEN);
      chk("interval", fb_lamp[3], SIL_BLUE);
      read_interval <= 1'b0;
      good_read <= 1'b1;
      cyc(1);
      good_read <= 1'b0;
      cyc(3);
      chk("good pulse", fb_lamp[0], SIL_GREEN);
      cyc(12);
      no_read <= 1'b1;
      cyc(1);
      no_read <= 1'b0;
      cyc(3);
      chk("no read pulse", fb_lamp[1], SIL_RED);
      ahb(1'b1, `SIL_OFS_CTRL, 32'h2b);
      fb_cmd <= 1'b1;
      cyc(3);
      chk("cmd colour", fb_lamp[2], SIL_RED);
      chk("full", fb_full[2], 1'b1);
      ahb(1'b1, `SIL_OFS_CTRL, 32'h29);
      cyc(3);
      chk("half", fb_full[1], 1'b0);
      fb_cmd <= 1'b0;
      ahb(1'b1, `SIL_OFS_CTRL, 32'h45);
      fb_eval_hit <= 1'b1;
      cyc(3);
      chk("eval colour", fb_lamp[0], SIL_GREEN);
      ahb(1'b1, `SIL_OFS_CTRL, 32'h44);
      cyc(3);
      chk("disabled", fb_lamp[0], SIL_OFF);
      fb_eval_hit <= 1'b0;
      // demo: configured red at half brightness must be overridden
      ahb(1'b1, `SIL_OFS_CTRL, 32'h89);
      cyc(3);
      chk("demo req", demo_read_req, 1'b1);
      chk("demo idle", fb_lamp[0], SIL_BLUE);
      chk("demo half", fb_full[0], 1'b0);
      for (int t = 1; t < 4; t++) begin
         tag_count <= 8'(t);
         hp = (t == 1) ? `SIL_HALF_TICKS(`SIL_P_1HZ25_MS) * TICK :
              (t == 2) ? `SIL_HALF_TICKS(`SIL_P_2HZ5_MS) * TICK :
              `SIL_HALF_TICKS(`SIL_P_5HZ_MS) * TICK;
         cyc(60);
         chk("demo blink", fb_half, hp);
         cyc(hp);
         chk("demo other half", fb_half, hp);
         while (fb_lamp[0] !== SIL_BLUE) @(posedge hclk);
         chk("demo full", fb_full[0], 1'b1);
      end
      chk("four alike", split_cnt, 0);
      end_sim();
   end
endmodule : sil_tb_top
`default_nettype wire
